// >>> bench/pitd_switch_bank.sv
// contact bank standing in for the switches wired to the input terminals
// assumes one system clock; contacts move just after its rising edge
`timescale 1ns/10ps
module pitd_switch_bank #(
    parameter int RST_HOLD = 16             // shortened minimum reset closure
) (
    input wire logic mclk_i,                 // system clock
    input wire logic [6:0] close_i,          // requested contact state
    input wire logic [6:0] rst_mask_i,       // pins wired as alarm reset
    output logic [6:0] term_pin_o            // contact levels, closed = 1
);
    int cnt [7] = '{default: 0};

    initial term_pin_o = 7'h00;

    // a reset contact stays closed for a minimum time once it has closed,
    // so a short request from the bench can never make a too-short pulse
    always @(posedge mclk_i) begin
        for (int k = 0; k < 7; k++) begin
            if (term_pin_o[k] && rst_mask_i[k] && cnt[k] < RST_HOLD) begin
                cnt[k] <= cnt[k] + 1;
            end else begin
                term_pin_o[k] <= close_i[k];
                cnt[k] <= 0;
            end
        end
    end
endmodule

// >>> bench/testbench.sv
// self-checking bench for the input terminal decoder
// assumes the decoder with its default frequency width and a contact bank
`timescale 1ns/10ps
module testbench;
    import pitd_pkg::*;
    logic mclk_i = 1'b0, resetn_i = 1'b0, jog_key_i = 1'b0;
    logic stopped = 1'b1, wr = 1'b0;
    logic [6:0] close = 7'h00, rst_mask = 7'h00;
    logic [10:0] code [7] = '{PITD_DEF_X1, PITD_DEF_X2, PITD_DEF_X3,
        PITD_DEF_X4, PITD_DEF_X5, PITD_DEF_FWD, PITD_DEF_REV};
    logic [1:0] src = 2'h1;
    logic [3:0] addr = 4'h0, idx;
    logic [15:0] ref_v = 16'h0000, data = 16'h0000, fcmd;
    logic [15:0] slot [16];
    logic [6:0] pin;
    logic ramp, run_forward_cmd, run_reverse_cmd, coast, dis, fault_alarm_out, disp, hold, dcb, fstop, jog;
    logic [35:0] ext;
    logic [31:0] seed = 32'hf9f9;
    int n_mismatch = 0, compares = 0;
    int ext_list [19] = '{11, 12, 14, 17, 18, 19, 20, 21, 24, 25, 26, 27,
        33, 34, 42, 43, 44, 45, 46};

    always #4 mclk_i = ~mclk_i;

    pitd_switch_bank pitd_switch_bank_inst (.mclk_i(mclk_i),
        .close_i(close), .rst_mask_i(rst_mask), .term_pin_o(pin));

    pitd_decoder pitd_decoder_inst (.mclk_i(mclk_i), .resetn_i(resetn_i),
        .term_pin_i(pin), .input1_assign_code_i(code[0]),
        .input2_assign_code_i(code[1]), .input3_assign_code_i(code[2]),
        .input4_assign_code_i(code[3]), .input5_assign_code_i(code[4]),
        .fwd_terminal_assign_code_i(code[5]),
        .rev_terminal_assign_code_i(code[6]),
        .run_source_setting_i(src), .jog_key_i(jog_key_i),
        .output_stopped_i(stopped), .freq_ref_i(ref_v),
        .preset_wr_i(wr), .preset_addr_i(addr), .preset_data_i(data),
        .preset_index_o(idx), .freq_cmd_o(fcmd), .ramp_set_two_o(ramp),
        .run_forward_o(run_forward_cmd), .run_reverse_o(run_reverse_cmd), .coast_stop_o(coast),
        .output_disable_o(dis), .fault_alarm_out_o(fault_alarm_out),
        .ext_alarm_disp_o(disp), .trip_hold_o(hold), .dc_brake_o(dcb),
        .force_stop_o(fstop), .jog_ready_o(jog), .ext_cmd_o(ext));

    // xorshift keeps the random stream repeatable from run to run
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %0h expected %0h",
                $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        if (n_mismatch == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // a fixed wait covers the documented pin-to-output latency with margin
    task automatic settle(input int n);
        repeat (n) @(negedge mclk_i);
    endtask

    task automatic key();
        @(negedge mclk_i) jog_key_i = 1'b1;
        @(negedge mclk_i) jog_key_i = 1'b0;
        settle(6);
    endtask

    // five general terminals at once; 98 there decodes to nothing
    task automatic setc(input logic [10:0] a, b, c, d, e);
        code[0] = a;
        code[1] = b;
        code[2] = c;
        code[3] = d;
        code[4] = e;
    endtask

    // a hang is cut short and counted as a mismatch
    initial begin
        repeat (60000) @(posedge mclk_i);
        n_mismatch++;
        stop_test();
    end

    initial begin
        logic [31:0] r;
        int e;
        settle(20);
        chk({fault_alarm_out, disp, hold, run_forward_cmd, run_reverse_cmd, jog}, 64'h0);
        resetn_i = 1'b1;
        for (int k = 1; k < 16; k++) begin
            @(negedge mclk_i);
            r = rnd();
            wr = 1'b1;
            addr = 4'(k);
            data = r[15:0];
            slot[k] = r[15:0];
        end
        @(negedge mclk_i) wr = 1'b0;
        // random contacts against the default assignment
        for (int i = 0; i < 24; i++) begin
            r = rnd();
            close = r[6:0];
            ref_v = r[31:16];
            settle(8);
            e = int'(close[3:0]);
            chk(idx, 64'(e));
            chk(fcmd, (e == 0) ? ref_v : slot[e]);
            chk(ramp, close[4]);
            chk(run_forward_cmd, close[5]);
            chk(run_reverse_cmd, close[6] & ~close[5]);
        end
        // inverted preset bit and unassigned ramp select with coast stop
        close = 7'h10;
        setc(11'h3e8, 11'h062, 11'h062, 11'h062, 11'h007);
        settle(8);
        chk(idx, 64'h1);
        chk(ramp, 64'h0);
        chk({coast, dis, fault_alarm_out}, 64'h6);
        // external trip latched, then alarm reset in two steps
        close = 7'h00;
        rst_mask = 7'h08;
        // let the pins settle first, or the new code meets a stale level
        settle(8);
        chk(coast, 64'h0);
        setc(11'h062, 11'h062, 11'h062, 11'h008, 11'h3f1);
        settle(8);
        chk({hold, fault_alarm_out, disp, dis}, 64'h0);
        close = 7'h10;
        settle(8);
        chk({hold, fault_alarm_out, disp, dis}, 64'hf);
        close = 7'h00;
        settle(8);
        chk({hold, fault_alarm_out, disp, dis}, 64'hf);
        close = 7'h08;
        settle(8);
        chk({fault_alarm_out, disp}, 64'h1);
        close = 7'h00;
        settle(24);
        chk({hold, fault_alarm_out, disp, dis}, 64'h0);
        code[4] = 11'h009;
        settle(8);
        chk({hold, fault_alarm_out}, 64'h3);
        close = 7'h18;
        settle(4);
        close = 7'h10;
        settle(24);
        chk({hold, fault_alarm_out, disp}, 64'h0);
        // forced stop is fail-safe in its base code
        rst_mask = 7'h00;
        close = 7'h00;
        setc(11'h062, 11'h01e, 11'h062, 11'h062, 11'h062);
        settle(8);
        chk(fstop, 64'h1);
        close = 7'h02;
        settle(8);
        chk(fstop, 64'h0);
        code[1] = 11'h406;
        settle(8);
        chk(fstop, 64'h1);
        // three-wire hold keeps the first run edge
        close = 7'h04;
        setc(11'h062, 11'h062, 11'h006, 11'h062, 11'h062);
        settle(8);
        close = 7'h24;
        settle(8);
        close = 7'h44;
        settle(8);
        chk({run_forward_cmd, run_reverse_cmd}, 64'h2);
        close = 7'h00;
        settle(8);
        chk({run_forward_cmd, run_reverse_cmd}, 64'h0);
        // keypad jog toggling and its restrictions
        src = 2'h0;
        setc(11'h00a, 11'h062, 11'h062, 11'h062, 11'h062);
        key();
        chk(jog, 64'h1);
        stopped = 1'b0;
        key();
        chk(jog, 64'h1);
        stopped = 1'b1;
        key();
        chk(jog, 64'h0);
        close = 7'h01;
        settle(8);
        chk(jog, 64'h1);
        key();
        chk(jog, 64'h1);
        src = 2'h1;
        close = 7'h00;
        key();
        chk(jog, 64'h0);
        close = 7'h01;
        settle(8);
        chk(jog, 64'h1);
        // decoded lines for outside functions, both senses
        foreach (ext_list[i]) begin
            code[0] = 11'(ext_list[i]);
            close = 7'h01;
            settle(8);
            chk(ext, 36'h1 << (ext_list[i] - 11));
            code[0] = 11'(ext_list[i] + 1000);
            close = 7'h00;
            settle(8);
            chk(ext, 36'h1 << (ext_list[i] - 11));
        end
        // braking and run codes have no inverted form or wrong terminal
        code[0] = 11'h00d;
        close = 7'h01;
        settle(8);
        chk(dcb, 64'h1);
        code[0] = 11'h3f5;
        close = 7'h00;
        settle(8);
        chk({dcb, ext}, 64'h0);
        code[0] = 11'h062;
        close = 7'h01;
        settle(8);
        chk({run_forward_cmd, run_reverse_cmd}, 64'h0);
        stop_test();
    end
endmodule

// >>> common/pitd_pkg.sv
// constants for the programmable input terminal decoder
// assumes one clock domain; codes arrive from configuration logic
package pitd_pkg;
    localparam int PITD_N_TERM = 7;          // x1..x5, forward, reverse
    localparam int PITD_CODE_W = 11;         // codes up to 1099
    localparam int PITD_BASE_W = 7;          // base codes up to 99
    localparam int PITD_FWD_TERM = 5;        // index of forward terminal
    localparam logic [10:0] PITD_INV_OFS = 11'h3e8;  // 1000 adds inversion
    // base command codes
    localparam logic [6:0] PITD_C_SEL0 = 7'h00;
    localparam logic [6:0] PITD_C_SEL1 = 7'h01;
    localparam logic [6:0] PITD_C_SEL2 = 7'h02;
    localparam logic [6:0] PITD_C_SEL3 = 7'h03;
    localparam logic [6:0] PITD_C_RAMP = 7'h04;
    localparam logic [6:0] PITD_C_HOLD = 7'h06;
    localparam logic [6:0] PITD_C_COAST = 7'h07;
    localparam logic [6:0] PITD_C_ARST = 7'h08;
    localparam logic [6:0] PITD_C_TRIP = 7'h09;
    localparam logic [6:0] PITD_C_JOG = 7'h0a;
    localparam logic [6:0] PITD_C_EXT_LO = 7'h0b;
    localparam logic [6:0] PITD_C_DC_BRAKE_CMD = 7'h0d;
    localparam logic [6:0] PITD_C_STOP = 7'h1e;
    localparam logic [6:0] PITD_C_EXT_HI = 7'h2e;
    localparam logic [6:0] PITD_C_FWD = 7'h62;
    localparam logic [6:0] PITD_C_REV = 7'h63;
    localparam int PITD_EXT_N = 36;          // lines for codes 11..46
    // run source setting value that selects the digital inputs
    localparam logic [1:0] PITD_SRC_DI = 2'h1;
    // assignment codes loaded at reset, all in non-inverted sense
    localparam logic [10:0] PITD_DEF_X1 = 11'h000;
    localparam logic [10:0] PITD_DEF_X2 = 11'h001;
    localparam logic [10:0] PITD_DEF_X3 = 11'h002;
    localparam logic [10:0] PITD_DEF_X4 = 11'h003;
    localparam logic [10:0] PITD_DEF_X5 = 11'h004;
    localparam logic [10:0] PITD_DEF_FWD = 11'h062;
    localparam logic [10:0] PITD_DEF_REV = 11'h063;
    // latched run direction, gray along idle -> fwd -> rev
    typedef enum logic [1:0] {
        PITD_RUN_IDLE = 2'b00,
        PITD_RUN_FWD = 2'b01,
        PITD_RUN_REV = 2'b11
    } pitd_run_t;
endpackage

// >>> src/pitd_decoder.sv
// input terminal decoder: seven pins into drive command lines
// assumes pins are asynchronous, all other inputs on mclk_i
`timescale 1ns/10ps
module pitd_decoder #(
    parameter int FREQ_W = 16               // frequency word width
) (
    input wire logic mclk_i,                 // 125 mhz system clock
    input wire logic resetn_i,               // async reset, active low
    input wire logic [6:0] term_pin_i,       // raw pins, on = 1
    input wire logic [10:0] input1_assign_code_i,  // code for x1
    input wire logic [10:0] input2_assign_code_i,  // code for x2
    input wire logic [10:0] input3_assign_code_i,  // code for x3
    input wire logic [10:0] input4_assign_code_i,  // code for x4
    input wire logic [10:0] input5_assign_code_i,  // code for x5
    input wire logic [10:0] fwd_terminal_assign_code_i, // code, fwd pin
    input wire logic [10:0] rev_terminal_assign_code_i, // code, rev pin
    input wire logic [1:0] run_source_setting_i,  // 1 = digital inputs
    input wire logic jog_key_i,              // keypad jog combo, pulse
    input wire logic output_stopped_i,       // output stage is stopped
    input wire logic [FREQ_W-1:0] freq_ref_i,  // normal reference
    input wire logic preset_wr_i,            // preset store write strobe
    input wire logic [3:0] preset_addr_i,    // preset slot 1..15
    input wire logic [FREQ_W-1:0] preset_data_i, // preset value
    output logic [3:0] preset_index_o,       // preset select index
    output logic [FREQ_W-1:0] freq_cmd_o,    // selected frequency
    output logic ramp_set_two_o,             // 1 = ramp time set two
    output logic run_forward_o,              // effective forward run
    output logic run_reverse_o,              // effective reverse run
    output logic coast_stop_o,               // coast stop active
    output logic output_disable_o,           // output stage shut off
    output logic fault_alarm_out_o,          // alarm relay
    output logic ext_alarm_disp_o,           // external alarm display
    output logic trip_hold_o,                // trip latched
    output logic dc_brake_o,                 // dc braking command
    output logic force_stop_o,               // forced stop command
    output logic jog_ready_o,                // ready for jogging
    output logic [pitd_pkg::PITD_EXT_N-1:0] ext_cmd_o  // codes 11..46
);
    import pitd_pkg::*;

    // refuse widths the reference path and preset store cannot serve
    if (FREQ_W < 1 || FREQ_W > 32) begin : g_bad_freq_w
        $error("FREQ_W must lie in 1..32");
    end

    // base code, inversion flag and validity of one assignment code
    function automatic logic [8:0] pitd_decode(
        input logic [10:0] code,
        input logic run_term
    );
        logic inv;
        logic ok;
        logic [10:0] full;
        logic [6:0] b;
        inv = (code >= PITD_INV_OFS);
        full = inv ? code - PITD_INV_OFS : code;
        b = full[6:0];
        ok = (full <= {4'h0, PITD_C_EXT_HI});
        if (inv && full[6:0] == PITD_C_DC_BRAKE_CMD) begin
            ok = 1'b0;
        end
        if ((full == {4'h0, PITD_C_FWD}) || (full == {4'h0, PITD_C_REV})) begin
            ok = run_term && !inv;
        end
        return {ok, inv, b};
    endfunction

    // codes are re-captured each cycle; reset leaves the defaults
    logic [10:0] code_q [PITD_N_TERM];
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            code_q[0] <= PITD_DEF_X1;
            code_q[1] <= PITD_DEF_X2;
            code_q[2] <= PITD_DEF_X3;
            code_q[3] <= PITD_DEF_X4;
            code_q[4] <= PITD_DEF_X5;
            code_q[5] <= PITD_DEF_FWD;
            code_q[6] <= PITD_DEF_REV;
        end else begin
            code_q[0] <= input1_assign_code_i;
            code_q[1] <= input2_assign_code_i;
            code_q[2] <= input3_assign_code_i;
            code_q[3] <= input4_assign_code_i;
            code_q[4] <= input5_assign_code_i;
            code_q[5] <= fwd_terminal_assign_code_i;
            code_q[6] <= rev_terminal_assign_code_i;
        end
    end

    // two flops per pin; only the second stage feeds any logic
    logic [6:0] pin_m_q;
    logic [6:0] pin_s_q;
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_m_q <= 7'h00;
            pin_s_q <= 7'h00;
        end else begin
            pin_m_q <= term_pin_i;
            pin_s_q <= pin_m_q;
        end
    end

    // per terminal: active and assigned one-hot over base codes
    logic [127:0] t_act [PITD_N_TERM];
    logic [127:0] t_asg [PITD_N_TERM];
    genvar g;
    generate
        for (g = 0; g < PITD_N_TERM; g++) begin : g_term
            logic [8:0] dec;
            logic lvl;
            logic fs;
            assign dec = pitd_decode(code_q[g], g >= PITD_FWD_TERM);
            // fail-safe codes act in the off state in their base form
            assign fs = (dec[6:0] == PITD_C_TRIP) ||
                        (dec[6:0] == PITD_C_STOP);
            assign lvl = pin_s_q[g] ^ dec[7] ^ fs;
            assign t_asg[g] = dec[8] ? (128'h1 << dec[6:0]) : 128'h0;
            assign t_act[g] = lvl ? t_asg[g] : 128'h0;
        end
    endgenerate

    logic [127:0] act_d;
    logic [127:0] asg_d;
    always_comb begin
        act_d = 128'h0;
        asg_d = 128'h0;
        for (int t = 0; t < PITD_N_TERM; t++) begin
            act_d = act_d | t_act[t];
            asg_d = asg_d | t_asg[t];
        end
    end

    // decoded commands, registered so edges follow inversion
    logic [127:0] act_q;
    logic [127:0] act_p_q;
    logic [127:0] asg_q;
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            act_q <= 128'h0;
            act_p_q <= 128'h0;
            asg_q <= 128'h0;
        end else begin
            act_q <= act_d;
            act_p_q <= act_q;
            asg_q <= asg_d;
        end
    end

    logic [3:0] sel;
    assign sel = {act_q[PITD_C_SEL3], act_q[PITD_C_SEL2],
                  act_q[PITD_C_SEL1], act_q[PITD_C_SEL0]};

    // preset store; slot 0 is never read, the reference takes its place
    logic [FREQ_W-1:0] preset_mem [16];
    always_ff @(posedge mclk_i) begin
        if (preset_wr_i && preset_addr_i != 4'h0) begin
            preset_mem[preset_addr_i] <= preset_data_i;
        end
    end

    // frequency selection and plain command lines
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            preset_index_o <= 4'h0;
            freq_cmd_o <= '0;
            ramp_set_two_o <= 1'b0;
            dc_brake_o <= 1'b0;
            force_stop_o <= 1'b0;
            coast_stop_o <= 1'b0;
            ext_cmd_o <= '0;
        end else begin
            preset_index_o <= sel;
            freq_cmd_o <= (sel == 4'h0) ? freq_ref_i
                                        : preset_mem[sel];
            // unassigned ramp select reads inactive, so set one holds
            ramp_set_two_o <= act_q[PITD_C_RAMP];
            dc_brake_o <= act_q[PITD_C_DC_BRAKE_CMD];
            force_stop_o <= act_q[PITD_C_STOP];
            coast_stop_o <= act_q[PITD_C_COAST];
            ext_cmd_o <= act_q[PITD_C_EXT_HI:PITD_C_EXT_LO];
        end
    end

    // run latching; without a hold terminal forward passes through and reverse passes only while forward is off
    pitd_run_t run_q;
    logic fwd_in;
    logic rev_in;
    logic fwd_rise;
    logic rev_rise;
    logic hold_on;
    assign fwd_in = act_q[PITD_C_FWD];
    assign rev_in = act_q[PITD_C_REV];
    assign fwd_rise = fwd_in && !act_p_q[PITD_C_FWD];
    assign rev_rise = rev_in && !act_p_q[PITD_C_REV];
    assign hold_on = act_q[PITD_C_HOLD];
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            run_q <= PITD_RUN_IDLE;
        end else begin
            case (run_q)
                PITD_RUN_IDLE: begin
                    // forward wins if both edges land together
                    if (hold_on && fwd_rise) begin
                        run_q <= PITD_RUN_FWD;
                    end else if (hold_on && rev_rise) begin
                        run_q <= PITD_RUN_REV;
                    end
                end
                PITD_RUN_FWD, PITD_RUN_REV: begin
                    if (!hold_on) begin
                        run_q <= PITD_RUN_IDLE;
                    end
                end
                default: run_q <= PITD_RUN_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            run_forward_o <= 1'b0;
            run_reverse_o <= 1'b0;
        end else if (!asg_q[PITD_C_HOLD]) begin
            run_forward_o <= fwd_in;
            run_reverse_o <= rev_in && !fwd_in;
        end else begin
            run_forward_o <= (run_q == PITD_RUN_FWD);
            run_reverse_o <= (run_q == PITD_RUN_REV);
        end
    end

    // trip and alarm; a new trip wins over a reset in the same cycle
    logic trip_rise;
    logic arst_on;
    logic arst_fall;
    assign trip_rise = act_q[PITD_C_TRIP] && !act_p_q[PITD_C_TRIP];
    assign arst_on = act_q[PITD_C_ARST];
    assign arst_fall = !arst_on && act_p_q[PITD_C_ARST];
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fault_alarm_out_o <= 1'b0;
            ext_alarm_disp_o <= 1'b0;
            trip_hold_o <= 1'b0;
        end else begin
            if (trip_rise) begin
                fault_alarm_out_o <= 1'b1;
            end else if (arst_on || arst_fall) begin
                // the release also clears, so no alarm outlives its hold
                fault_alarm_out_o <= 1'b0;
            end
            if (trip_rise) begin
                ext_alarm_disp_o <= 1'b1;
                trip_hold_o <= 1'b1;
            end else if (arst_fall) begin
                ext_alarm_disp_o <= 1'b0;
                trip_hold_o <= 1'b0;
            end
        end
    end

    // output shut off follows the combined causes a cycle late
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            output_disable_o <= 1'b0;
        end else begin
            output_disable_o <= act_q[PITD_C_COAST] || trip_rise ||
                                trip_hold_o;
        end
    end

    // jog state; the keypad toggle is held apart from the terminal
    logic kp_jog_q;
    logic jog_tgt;
    logic kp_src;
    assign kp_src = (run_source_setting_i != PITD_SRC_DI);
    assign jog_tgt = act_q[PITD_C_JOG] || (kp_src && kp_jog_q);
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            kp_jog_q <= 1'b0;
            jog_ready_o <= 1'b0;
        end else begin
            // a key press while running is dropped, not queued
            if (kp_src && jog_key_i && !act_q[PITD_C_JOG] &&
                output_stopped_i) begin
                kp_jog_q <= !jog_ready_o;
            end else if (!kp_src || act_q[PITD_C_JOG]) begin
                kp_jog_q <= 1'b0;
            end
            if (output_stopped_i) begin
                jog_ready_o <= jog_tgt;
            end
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    trip_sets_alarm_a: assert property (
        trip_rise |=> fault_alarm_out_o && ext_alarm_disp_o && trip_hold_o)
        else $error("trip did not raise alarm");
    trip_stays_held_a: assert property (
        trip_hold_o && !trip_rise && !arst_fall |=> trip_hold_o)
        else $error("trip latch dropped without reset");
    reset_clears_alarm_a: assert property (
        arst_on && !trip_rise |=> !fault_alarm_out_o)
        else $error("alarm reset did not clear alarm");
    coast_disables_a: assert property (
        act_q[PITD_C_COAST] |=> output_disable_o && !fault_alarm_out_o
            || $past(trip_rise) || trip_hold_o)
        else $error("coast stop did not disable output");
    two_wire_run_a: assert property (
        !asg_q[PITD_C_HOLD] |=> run_forward_o == $past(fwd_in))
        else $error("two-wire run not followed");
    hold_latch_a: assert property (
        run_q == PITD_RUN_FWD && asg_q[PITD_C_HOLD] && hold_on
            |=> run_forward_o ##1 (run_q != PITD_RUN_IDLE || !$past(hold_on)))
        else $error("latched run lost while hold on");
    jog_only_stopped_a: assert property (
        !output_stopped_i |=> $stable(jog_ready_o))
        else $error("jog state changed while running");
    jog_follows_di_a: assert property (
        !kp_src && output_stopped_i |=> jog_ready_o == $past(act_q[PITD_C_JOG]))
        else $error("jog state not following terminal");
    preset_index_a: assert property (
        sel == 4'h0 |=> freq_cmd_o == $past(freq_ref_i) && preset_index_o == 4'h0)
        else $error("index zero did not pass reference");
    ramp_default_a: assert property (
        !asg_q[PITD_C_RAMP] |=> !ramp_set_two_o)
        else $error("ramp set two without assignment");
endmodule
